// [snc_config_regs.sv]
/*
 * node configuration register bank of a packet-switch node: identity,
 * write locks, header mode, node number, clock generator settings,
 * clock dividers, routing directions and tile 0 debug pin control.
 * assumes a configuration access port on core_clk that holds each request
 * for one cycle, a clock multiplier that reports lock, and an active low
 * open-drain shared debug line resolved outside this block.
 */
// Summary of operation
// - identity shows boot pins, revision, version
// - description shows links, tile processors counts
// - config bit 31 blocks control register writes
// - config bit 8 blocks clock multiplier writes
// - config bit 0 selects one-byte headers
// - sixteen-bit writable node number, resets zero
// - clock multiplier write resets the tile
// - settings bit 31 suppresses that tile reset
// - settings bit 30 skips waiting for relock
// - settings bit 29 bypasses the multiplying loop
// - settings bit 28 forces boot from test port
// - output divider field bits 25:23, value+1
// - feedback multiplier bits 20:8, value+1
// - input divider field bits 6:0, value+1
// - switch clock divider sixteen bits, resets zero
// - reference clock divider sixteen bits, resets 3
// - user code shows fused code, metal id
// - route by most significant mismatching id bit
// - low directions: eight nibbles, positions 7..0
// - high directions: eight nibbles, positions 15..8
// - debug line raises tile request when enabled
// - halted flag drives debug line when enabled
`timescale 1ns/100ps
`include "snc_consts.svh"
module snc_config_regs
    import snc_pkg::*;
#(
    parameter logic [7:0] SWITCH_REVISION = 8'h01, // arbitrary value
    parameter logic [7:0] SWITCH_VERSION = 8'h02, // arbitrary value
    parameter logic [31:0] TEST_PORT_ID = 32'h1234_5001, // arbitrary value
    parameter logic [17:0] METAL_ID = 18'h0_0001, // arbitrary value
    parameter logic [7:0] NUM_SERIAL_LINKS = 8'h08,
    parameter logic [7:0] NUM_SWITCH_PROCS = 8'h02,
    parameter logic [7:0] NUM_DEVICE_PROCS = 8'h02
) (
    input wire logic core_clk,
    input wire logic rst,
    // configuration access port
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_regnum,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic cfg_err,
    output logic [31:0] cfg_rdata,
    // boot straps and fused code
    input wire logic [7:0] boot_control_pins,
    input wire logic [13:0] otp_user_code,
    // switch settings
    output logic header_one_byte,
    output logic [15:0] node_id,
    output logic [15:0] switch_clk_div,
    output logic [15:0] ref_clk_div,
    // clock multiplier
    input wire logic clk_mult_locked,
    output logic clk_mult_bypass,
    output logic boot_from_jtag,
    output logic [2:0] clk_mult_out_div,
    output logic [12:0] clk_mult_fb_mul,
    output logic [6:0] clk_mult_in_div,
    output logic clk_mult_update,
    output logic tile_reset,
    // routing lookup
    input wire logic route_req,
    input wire logic [15:0] route_dest_id,
    output logic route_valid,
    output logic route_local,
    output logic [3:0] route_dir,
    // tile 0 debug
    input wire logic core_halted_flag,
    input wire logic shared_debug_line_n_in,
    output logic shared_debug_line_n_out,
    output logic shared_debug_line_n_oe,
    output logic tile_processor_debug_req
);
    typedef struct packed {
        logic ack; // access answer strobe
        logic err; // unmapped register number
        logic [31:0] rdata; // read answer
        logic [1:0] boot_cnt; // edges since release, stops at settle
        logic [7:0] boot_pins; // pin levels after power-on reset
        logic lock_all; // control register write lock
        logic lock_clkgen; // clock multiplier write lock
        logic one_byte_hdr; // header mode
        logic [15:0] node_id; // this node's number
        logic cg_no_reset; // settings bit 31
        logic cg_no_wait; // settings bit 30
        logic cg_bypass; // settings bit 29
        logic cg_jtag_boot; // settings bit 28
        logic [2:0] cg_out_div; // output divider code
        logic [12:0] cg_fb_mul; // feedback multiplier code
        logic [6:0] cg_in_div; // input divider code
        snc_cg_state_t cg_state; // update sequencing
        logic cg_update; // apply strobe to the multiplier
        logic tile_reset; // tile held in reset
        logic [15:0] sw_div; // switch clock divider
        logic [15:0] ref_div; // reference clock divider
        logic [31:0] dir_lo; // directions for positions 7..0
        logic [31:0] dir_hi; // directions for positions 15..8
        logic dbg_req_en; // debug line to processor request
        logic dbg_drive_en; // halted flag onto debug line
        logic dbg_req; // request to the tile processor
        logic dbg_drive; // pulling the debug line low
    } snc_state_t;

    snc_state_t state;
    snc_state_t next_state;

    logic [7:0] boot_sync; // straps after two flops
    logic locked_sync; // multiplier lock after two flops
    logic dbg_line_n_sync; // shared debug line after two flops

    // pins arrive from outside core_clk and are synchronised first
    snc_sync2 #(
        .WIDTH(8),
        .RESET_VAL(8'h00)
    ) u_boot_sync (
        .core_clk(core_clk),
        .rst(rst),
        .d(boot_control_pins),
        .q(boot_sync)
    );

    snc_sync2 #(
        .WIDTH(2),
        .RESET_VAL(2'h1)
    ) u_misc_sync (
        .core_clk(core_clk),
        .rst(rst),
        .d({clk_mult_locked, shared_debug_line_n_in}),
        .q({locked_sync, dbg_line_n_sync})
    );

    // routing lookup runs beside the register bank on its tables
    snc_route_lookup #(
        .ID_W(16),
        .DIR_W(4)
    ) u_route (
        .core_clk(core_clk),
        .rst(rst),
        .lookup_valid(route_req),
        .own_id(state.node_id),
        .dest_id(route_dest_id),
        .dir_table({state.dir_hi, state.dir_lo}),
        .dir_valid(route_valid),
        .is_local(route_local),
        .dir(route_dir)
    );

    // register access, locks, clock multiplier sequencing and debug
    always_comb begin
        logic wr; // accepted write strobe
        logic [31:0] rd; // read mux result
        logic hit; // register number is mapped
        wr = cfg_req && cfg_write;
        rd = 32'h0000_0000;
        hit = 1'b1;
        next_state = state;
        next_state.ack = cfg_req;
        next_state.cg_update = 1'b0;

        // the synchroniser is cleared by reset too, so the pin level only
        // reaches its output at the second edge after release and this register at the third; keep taking
        // it until then and freeze it from that edge on. a read of the
        // identity register before that edge shows the straps as zero
        if (state.boot_cnt != `SNC_BOOT_SETTLE) begin
            next_state.boot_cnt = state.boot_cnt + 2'h1;
            next_state.boot_pins = boot_sync;
        end

        // read mux; reserved bits stay zero
        unique case (cfg_regnum)
            `SNC_REG_NODE_IDENT: begin
                rd = {8'h00, state.boot_pins, SWITCH_REVISION,
                      SWITCH_VERSION};
            end
            `SNC_REG_SWITCH_DESC: begin
                rd = {8'h00, NUM_SERIAL_LINKS, NUM_SWITCH_PROCS,
                      NUM_DEVICE_PROCS};
            end
            `SNC_REG_SWITCH_CFG: begin
                rd[`SNC_CFG_LOCK_ALL_BIT] = state.lock_all;
                rd[`SNC_CFG_LOCK_CLKGEN_BIT] = state.lock_clkgen;
                rd[`SNC_CFG_HDR_BIT] = state.one_byte_hdr;
            end
            `SNC_REG_NODE_ID: begin
                rd[15:0] = state.node_id;
            end
            `SNC_REG_CLK_MULT: begin
                rd[`SNC_CG_NO_RESET_BIT] = state.cg_no_reset;
                rd[`SNC_CG_NO_WAIT_BIT] = state.cg_no_wait;
                rd[`SNC_CG_BYPASS_BIT] = state.cg_bypass;
                rd[`SNC_CG_JTAG_BOOT_BIT] = state.cg_jtag_boot;
                rd[`SNC_CG_OUT_DIV_HI:`SNC_CG_OUT_DIV_LO] = state.cg_out_div;
                rd[`SNC_CG_FB_MUL_HI:`SNC_CG_FB_MUL_LO] = state.cg_fb_mul;
                rd[`SNC_CG_IN_DIV_HI:`SNC_CG_IN_DIV_LO] = state.cg_in_div;
            end
            `SNC_REG_SW_CLK_DIV: begin
                rd[15:0] = state.sw_div;
            end
            `SNC_REG_REF_CLK_DIV: begin
                rd[15:0] = state.ref_div;
            end
            `SNC_REG_TEST_ID: begin
                rd = TEST_PORT_ID;
            end
            `SNC_REG_USER_CODE: begin
                rd = {otp_user_code, METAL_ID};
            end
            `SNC_REG_DIR_LOW: begin
                rd = state.dir_lo;
            end
            `SNC_REG_DIR_HIGH: begin
                rd = state.dir_hi;
            end
            `SNC_REG_DEBUG_T0: begin
                rd[`SNC_DBG_REQ_EN_BIT] = state.dbg_req_en;
                rd[`SNC_DBG_DRIVE_EN_BIT] = state.dbg_drive_en;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        next_state.err = cfg_req && !hit;
        next_state.rdata = (cfg_req && !cfg_write) ? rd : 32'h0000_0000;

        // writes: the global lock also freezes the lock bits themselves,
        // so once set it holds until reset, which is the point of it
        if (wr && !state.lock_all) begin
            unique case (cfg_regnum)
                `SNC_REG_SWITCH_CFG: begin
                    next_state.lock_all = cfg_wdata[`SNC_CFG_LOCK_ALL_BIT];
                    next_state.lock_clkgen =
                        cfg_wdata[`SNC_CFG_LOCK_CLKGEN_BIT];
                    next_state.one_byte_hdr =
                        cfg_wdata[`SNC_CFG_HDR_BIT];
                end
                `SNC_REG_NODE_ID: begin
                    next_state.node_id = cfg_wdata[15:0];
                end
                `SNC_REG_CLK_MULT: begin
                    if (!state.lock_clkgen) begin
                        next_state.cg_no_reset =
                            cfg_wdata[`SNC_CG_NO_RESET_BIT];
                        next_state.cg_no_wait =
                            cfg_wdata[`SNC_CG_NO_WAIT_BIT];
                        next_state.cg_bypass =
                            cfg_wdata[`SNC_CG_BYPASS_BIT];
                        next_state.cg_jtag_boot =
                            cfg_wdata[`SNC_CG_JTAG_BOOT_BIT];
                        next_state.cg_out_div = cfg_wdata[
                            `SNC_CG_OUT_DIV_HI:`SNC_CG_OUT_DIV_LO];
                        next_state.cg_fb_mul = cfg_wdata[
                            `SNC_CG_FB_MUL_HI:`SNC_CG_FB_MUL_LO];
                        next_state.cg_in_div = cfg_wdata[
                            `SNC_CG_IN_DIV_HI:`SNC_CG_IN_DIV_LO];
                        next_state.cg_update = 1'b1;
                        // every accepted write resets the tile unless told
                        next_state.tile_reset =
                            !cfg_wdata[`SNC_CG_NO_RESET_BIT];
                        // lock wait is skipped for gradual changes
                        next_state.cg_state =
                            cfg_wdata[`SNC_CG_NO_WAIT_BIT] ?
                            SNC_CG_IDLE : SNC_CG_WAIT_LOCK;
                    end
                end
                `SNC_REG_SW_CLK_DIV: begin
                    next_state.sw_div = cfg_wdata[15:0];
                end
                `SNC_REG_REF_CLK_DIV: begin
                    next_state.ref_div = cfg_wdata[15:0];
                end
                `SNC_REG_DIR_LOW: begin
                    next_state.dir_lo = cfg_wdata;
                end
                `SNC_REG_DIR_HIGH: begin
                    next_state.dir_hi = cfg_wdata;
                end
                `SNC_REG_DEBUG_T0: begin
                    next_state.dbg_req_en = cfg_wdata[`SNC_DBG_REQ_EN_BIT];
                    next_state.dbg_drive_en =
                        cfg_wdata[`SNC_DBG_DRIVE_EN_BIT];
                end
                default: begin
                    next_state.cg_update = 1'b0; // read-only or unmapped
                end
            endcase
        end else if (state.cg_state == SNC_CG_WAIT_LOCK) begin
            // the update cycle itself never ends the wait, but locked_sync lags by two flops, so a lock
            // still high from the old settings is taken as relock in the cycle after the update
            if (locked_sync && !state.cg_update) begin
                next_state.cg_state = SNC_CG_IDLE;
                next_state.tile_reset = 1'b0;
            end
        end else begin
            // no lock wait: the reset ends at the first cycle without an accepted write
            next_state.tile_reset = 1'b0;
        end

        // debug line is active low; sampled level low means asserted
        next_state.dbg_req = state.dbg_req_en && !dbg_line_n_sync;
        next_state.dbg_drive = state.dbg_drive_en &&
            core_halted_flag;
    end

    // single state register; reset values live in the header
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= '0;
            state.cg_state <= SNC_CG_IDLE;
            state.node_id <= `SNC_RST_ZERO16;
            state.sw_div <= `SNC_RST_ZERO16;
            state.ref_div <= `SNC_RST_REF_DIV;
            state.cg_out_div <= `SNC_RST_CG_OUT_DIV;
            state.cg_fb_mul <= `SNC_RST_CG_FB_MUL;
            state.cg_in_div <= `SNC_RST_CG_IN_DIV;
            state.dir_lo <= `SNC_RST_DIR;
            state.dir_hi <= `SNC_RST_DIR;
        end else begin
            state <= next_state;
        end
    end

    // outputs come straight from the state register, except shared_debug_line_n_out, tied low, and route_valid, route_local and route_dir from the lookup
    assign cfg_ack = state.ack;
    assign cfg_err = state.err;
    assign cfg_rdata = state.rdata;
    assign header_one_byte = state.one_byte_hdr;
    assign node_id = state.node_id;
    assign switch_clk_div = state.sw_div;
    assign ref_clk_div = state.ref_div;
    assign clk_mult_bypass = state.cg_bypass;
    assign boot_from_jtag = state.cg_jtag_boot;
    assign clk_mult_out_div = state.cg_out_div;
    assign clk_mult_fb_mul = state.cg_fb_mul;
    assign clk_mult_in_div = state.cg_in_div;
    assign clk_mult_update = state.cg_update;
    assign tile_reset = state.tile_reset;
    assign shared_debug_line_n_out = 1'b0; // open drain: only pulls low
    assign shared_debug_line_n_oe = state.dbg_drive;
    assign tile_processor_debug_req = state.dbg_req;
endmodule

// [snc_config_regs_chk.sv]
/* port checker of the node configuration register bank.
   assumes it is bound into snc_config_regs, one clock, rst high. */
`timescale 1ns/100ps
module snc_config_regs_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_regnum,
    input wire logic [31:0] cfg_wdata,
    input wire logic cfg_ack,
    input wire logic cfg_err,
    input wire logic [31:0] cfg_rdata,
    input wire logic [15:0] node_id,
    input wire logic clk_mult_bypass,
    input wire logic boot_from_jtag,
    input wire logic clk_mult_update,
    input wire logic tile_reset,
    input wire logic route_req,
    input wire logic [15:0] route_dest_id,
    input wire logic route_valid,
    input wire logic route_local,
    input wire logic core_halted_flag,
    input wire logic shared_debug_line_n_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // a write aimed at the clock multiplier settings
    sequence cg_write;
        cfg_req && cfg_write && cfg_regnum == 8'h06;
    endsequence
    // that write followed by its update strobe
    sequence cg_update;
        cg_write ##1 clk_mult_update;
    endsequence
    chk_ack_follows: assert property (cfg_req |=> cfg_ack)
        else $error("no answer after a request");
    chk_err_zero: assert property (cfg_err |-> cfg_ack && !cfg_rdata)
        else $error("error answer without zero data");
    chk_node_cause: assert property ($changed(node_id) |->
        $past(cfg_req && cfg_write && cfg_regnum == 8'h05))
        else $error("node number changed without a write");
    chk_update_cause: assert property (clk_mult_update |->
        $past(cfg_req && cfg_write && cfg_regnum == 8'h06))
        else $error("update strobe without a settings write");
    chk_reset_gate: assert property (cg_update |->
        tile_reset == !$past(cfg_wdata[31]))
        else $error("tile reset does not follow bit 31");
    chk_no_wait: assert property ((cg_write and
        (cfg_wdata[30] && !cfg_wdata[31])) ##1 clk_mult_update |=> !tile_reset)
        else $error("tile reset held despite bit 30");
    chk_mode_bits: assert property (cg_update |->
        clk_mult_bypass == $past(cfg_wdata[29]) &&
        boot_from_jtag == $past(cfg_wdata[28]))
        else $error("bypass or boot mode not taken");
    chk_route_answer: assert property (route_req |=> route_valid &&
        route_local == ($past(route_dest_id) == $past(node_id)))
        else $error("route answer wrong");
    chk_drive_cause: assert property (
        $rose(shared_debug_line_n_oe) |-> $past(core_halted_flag))
        else $error("debug line driven without halted flag");
endmodule
bind snc_config_regs snc_config_regs_chk u_chk (.*);

// [snc_config_regs_tb_top.sv]
/* self-checking bench of the node configuration register bank.
   assumes default identity parameters; inputs change at falling edges. */
`timescale 1ns/100ps
module snc_config_regs_tb_top;
    logic core_clk, rst, cfg_req, cfg_write, cfg_ack, cfg_err;
    logic [7:0] cfg_regnum, boot_control_pins;
    logic [31:0] cfg_wdata, cfg_rdata, r;
    logic [13:0] otp_user_code;
    logic [15:0] node_id, switch_clk_div, ref_clk_div, route_dest_id;
    logic header_one_byte, clk_mult_locked, clk_mult_bypass, boot_from_jtag;
    logic [2:0] clk_mult_out_div;
    logic [12:0] clk_mult_fb_mul;
    logic [6:0] clk_mult_in_div;
    logic clk_mult_update, tile_reset, route_req, route_valid, route_local;
    logic [3:0] route_dir;
    logic core_halted_flag, shared_debug_line_n_in, shared_debug_line_n_out;
    logic shared_debug_line_n_oe, tile_processor_debug_req;
    int n_errors = 0;
    int total_checks = 0;
    int i;
    // mapped registers with their values after reset
    localparam logic [7:0] rn [12] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06,
        8'h07, 8'h08, 8'h09, 8'h0A, 8'h0C, 8'h0D, 8'h10};
    localparam logic [31:0] rv [12] = '{32'h00A5_0102, 32'h0008_0202, 0, 0,
        0, 0, 32'h0000_0003, 32'h1234_5001, {14'h2AB5, 18'h0_0001}, 0, 0, 0};
    // writable registers: all-ones or a pattern, and what must read back
    localparam logic [7:0] wn [6] = '{8'h05, 8'h07, 8'h08, 8'h0C, 8'h0D,
        8'h10};
    localparam logic [31:0] wd [6] = '{'1, '1, '1, 32'h7654_3210,
        32'hFEDC_BA98, '1};
    localparam logic [31:0] we [6] = '{32'h0000_FFFF, 32'h0000_FFFF,
        32'h0000_FFFF, 32'h7654_3210, 32'hFEDC_BA98, 32'h0000_0003};

    snc_config_regs u_dut (.*);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // one comparison, reported at once when it differs
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic conclude();
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one access: request stands one cycle, answer stands the next one
    task automatic acc(input logic w, input logic [7:0] n,
            input logic [31:0] d);
        @(negedge core_clk);
        cfg_req = 1'b1;
        cfg_write = w;
        cfg_regnum = n;
        cfg_wdata = d;
        @(negedge core_clk);
        cfg_req = 1'b0;
        r = cfg_rdata;
        chk({31'h0000_0000, cfg_ack}, 32'h0000_0001);
    endtask

    task automatic rd(input logic [7:0] n, input logic [31:0] exp);
        acc(1'b0, n, 32'h0000_0000);
        chk(r, exp);
    endtask

    // lookup answers one cycle after the request
    task automatic route(input logic [15:0] dest, input logic [3:0] d,
            input logic loc);
        @(negedge core_clk);
        route_req = 1'b1;
        route_dest_id = dest;
        @(negedge core_clk);
        route_req = 1'b0;
        chk({route_valid, route_local, route_dir}, {1'b1, loc, d});
    endtask

    initial begin
        {rst, cfg_req, cfg_write, cfg_regnum, cfg_wdata} = '1;
        {cfg_req, cfg_write, route_req, core_halted_flag} = '0;
        {clk_mult_locked, route_dest_id} = '0;
        shared_debug_line_n_in = 1'b1;
        boot_control_pins = 8'hA5;
        otp_user_code = 14'h2AB5;
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        // straps reach the identity register three edges after release
        repeat (3) @(negedge core_clk);
        for (i = 0; i < 12; i++) rd(rn[i], rv[i]);
        // reserved bits drop, writable ones hold
        for (i = 0; i < 6; i++) begin
            acc(1'b1, wn[i], wd[i]);
            rd(wn[i], we[i]);
        end
        chk({node_id, ref_clk_div}, 32'hFFFF_FFFF);
        chk({16'h0000, switch_clk_div}, 32'h0000_FFFF);
        // read-only places ignore writes, unmapped number answers error
        acc(1'b1, 8'h00, 32'h0000_0000);
        rd(8'h00, rv[0]);
        acc(1'b1, 8'h0A, 32'h0000_0000);
        rd(8'h0A, rv[8]);
        rd(8'h0B, 32'h0000_0000);
        chk({31'h0000_0000, cfg_err}, 32'h0000_0001);
        // each mismatch position picks its own nibble; equal ids stay local
        for (i = 0; i < 16; i++) begin
            route(~((16'h0002 << i) - 1'b1), i[3:0], 1'b0);
        end
        route(16'hFFFF, 4'h0, 1'b1);
        // shared line low raises the request, halted flag pulls the line
        shared_debug_line_n_in = 1'b0;
        core_halted_flag = 1'b1;
        repeat (4) @(negedge core_clk);
        chk({tile_processor_debug_req, shared_debug_line_n_oe,
            shared_debug_line_n_out}, 3'b110);
        acc(1'b1, 8'h10, 32'h0000_0000);
        repeat (2) @(negedge core_clk);
        chk({tile_processor_debug_req, shared_debug_line_n_oe}, 0);
        shared_debug_line_n_in = 1'b1;
        core_halted_flag = 1'b0;
        // settings write of all ones except bits 31 and 30, with the loop unlocked
        acc(1'b1, 8'h06, 32'h3FFF_FFFF);
        chk({clk_mult_update, tile_reset, clk_mult_bypass, boot_from_jtag,
            clk_mult_out_div, clk_mult_fb_mul, clk_mult_in_div},
            {4'hF, 3'h7, 13'h1FFF, 7'h7F});
        acc(1'b0, 8'h06, 32'h0000_0000);
        chk(r, 32'h339F_FF7F);
        chk({31'h0000_0000, tile_reset}, 32'h0000_0001);
        clk_mult_locked = 1'b1;
        // tile reset must end once the loop reports lock
        for (i = 0; i < 10 && tile_reset !== 1'b0; i++) @(negedge core_clk);
        if (tile_reset !== 1'b0) begin
            n_errors++;
            conclude();
        end
        acc(1'b1, 8'h06, 32'h4000_0000);
        chk({31'h0000_0000, tile_reset}, 32'h0000_0001);
        @(negedge core_clk);
        chk({31'h0000_0000, tile_reset}, 32'h0000_0000);
        acc(1'b1, 8'h06, 32'h8000_0000);
        chk({clk_mult_update, tile_reset}, 2'b10);
        // clock generator lock and header mode
        acc(1'b1, 8'h04, 32'h7FFF_FFFF);
        rd(8'h04, 32'h0000_0101);
        chk({31'h0000_0000, header_one_byte}, 32'h0000_0001);
        acc(1'b1, 8'h06, 32'h2000_0000);
        chk({clk_mult_update, clk_mult_bypass}, 2'b00);
        // global lock freezes node number and the lock register itself
        acc(1'b1, 8'h04, 32'h8000_0101);
        acc(1'b1, 8'h05, 32'h0000_1234);
        rd(8'h05, 32'h0000_FFFF);
        acc(1'b1, 8'h04, 32'h0000_0000);
        rd(8'h04, 32'h8000_0101);
        conclude();
    end
endmodule

// [snc_consts.svh]
/*
 * constants of the node configuration register bank: register numbers,
 * field positions and reset values.
 * assumes it is included by bare name from the register bank module.
 */
`ifndef SNC_CONSTS_SVH
`define SNC_CONSTS_SVH

// register numbers on the configuration access port
`define SNC_REG_NODE_IDENT 8'h00
`define SNC_REG_SWITCH_DESC 8'h01
`define SNC_REG_SWITCH_CFG 8'h04
`define SNC_REG_NODE_ID 8'h05
`define SNC_REG_CLK_MULT 8'h06
`define SNC_REG_SW_CLK_DIV 8'h07
`define SNC_REG_REF_CLK_DIV 8'h08
`define SNC_REG_TEST_ID 8'h09
`define SNC_REG_USER_CODE 8'h0A
`define SNC_REG_DIR_LOW 8'h0C
`define SNC_REG_DIR_HIGH 8'h0D
`define SNC_REG_DEBUG_T0 8'h10

// switch configuration fields
`define SNC_CFG_LOCK_ALL_BIT 31
`define SNC_CFG_LOCK_CLKGEN_BIT 8
`define SNC_CFG_HDR_BIT 0

// clock multiplier settings fields
`define SNC_CG_NO_RESET_BIT 31
`define SNC_CG_NO_WAIT_BIT 30
`define SNC_CG_BYPASS_BIT 29
`define SNC_CG_JTAG_BOOT_BIT 28
`define SNC_CG_OUT_DIV_HI 25
`define SNC_CG_OUT_DIV_LO 23
`define SNC_CG_FB_MUL_HI 20
`define SNC_CG_FB_MUL_LO 8
`define SNC_CG_IN_DIV_HI 6
`define SNC_CG_IN_DIV_LO 0

// debug pin configuration fields
`define SNC_DBG_REQ_EN_BIT 1
`define SNC_DBG_DRIVE_EN_BIT 0

// reset values
`define SNC_RST_ZERO16 16'h0000
`define SNC_RST_REF_DIV 16'h0003
`define SNC_RST_CG_OUT_DIV 3'h0
`define SNC_RST_CG_FB_MUL 13'h0000
`define SNC_RST_CG_IN_DIV 7'h00
`define SNC_RST_DIR 32'h0000_0000

// edges after reset release until the identity register holds the strap pins
`define SNC_BOOT_SETTLE 2'h3

`endif

// [snc_pkg.sv]
/*
 * types shared by the node configuration register bank.
 * assumes snc_consts.svh sits in the same folder.
 */
package snc_pkg;
    // clock generator update sequencing
    typedef enum logic [0:0] {
        SNC_CG_IDLE,
        SNC_CG_WAIT_LOCK
    } snc_cg_state_t;
endpackage

// [snc_route_lookup.sv]
/*
 * route direction lookup: picks the direction of the most significant bit
 * in which a destination node number differs from this node's number.
 * assumes the direction table and own id are stable while looking up.
 */
`timescale 1ns/100ps
module snc_route_lookup #(
    parameter int ID_W = 16,
    parameter int DIR_W = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic lookup_valid,
    input wire logic [ID_W-1:0] own_id,
    input wire logic [ID_W-1:0] dest_id,
    input wire logic [ID_W*DIR_W-1:0] dir_table,
    output logic dir_valid,
    output logic is_local,
    output logic [DIR_W-1:0] dir
);
    typedef struct packed {
        logic valid; // answer strobe, one cycle after the request
        logic local_hit; // destination is this node
        logic [DIR_W-1:0] dir; // chosen direction
    } snc_rl_state_t;

    snc_rl_state_t state;
    snc_rl_state_t next_state;

    // scan upward so the highest mismatching position wins
    always_comb begin
        logic [ID_W-1:0] diff;
        diff = own_id ^ dest_id;
        next_state = state;
        next_state.valid = lookup_valid;
        if (lookup_valid) begin
            next_state.local_hit = (diff == '0);
            next_state.dir = '0;
            for (int i = 0; i < ID_W; i++) begin
                if (diff[i]) begin
                    next_state.dir = dir_table[i*DIR_W +: DIR_W];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign dir_valid = state.valid;
    assign is_local = state.local_hit;
    assign dir = state.dir;
endmodule

// [snc_sync2.sv]
/*
 * two flip-flop level synchroniser for pins entering core_clk.
 * assumes the input is a slow level; the first stage feeds only the second.
 */
`timescale 1ns/100ps
module snc_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1; // metastable catch stage
        logic [WIDTH-1:0] stage2; // settled copy
    } snc_sync_state_t;

    snc_sync_state_t state;
    snc_sync_state_t next_state;

    // shift the pin level through both stages
    always_comb begin
        next_state.stage1 = d;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= {RESET_VAL, RESET_VAL};
        end else begin
            state <= next_state;
        end
    end

    assign q = state.stage2;
endmodule
